// *** rtl/usm_consts.vh ***
/*
  Constants for the serial transceiver in master SPI mode: register offsets,
  field positions, reset values and mode codes.
  Assumes inclusion by usm_top.v only; definitions only.
*/
`ifndef USM_CONSTS_VH
`define USM_CONSTS_VH
`define USM_OFF_STAT 8'hC0
`define USM_OFF_CTLB 8'hC1
`define USM_OFF_CTLC 8'hC2
`define USM_OFF_DIVL 8'hC4
`define USM_OFF_DIVH 8'hC5
`define USM_OFF_DATA 8'hC6
`define USM_CTLC_RESET 8'h06
`define USM_BIT_RXC 7
`define USM_BIT_TXC 6
`define USM_BIT_DRE 5
`define USM_BIT_RXEN 4
`define USM_BIT_TXEN 3
`define USM_BIT_ORDER 2
`define USM_BIT_PHASE 1
`define USM_BIT_POL 0
`define USM_MODE_SPI 2'h3
`define USM_DIV_W 12
`define USM_FRAME_BITS 4'h8
`endif

// *** rtl/usm_top.v ***
/*
  Serial transceiver operating as a master SPI: Wishbone classic slave,
  12-bit baud generator, double-buffered transmit, two-level receive buffer.
  Assumes one 125 MHz clock, synchronous active-high reset, and a serial
  input that is synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "usm_consts.vh"
module usm_top
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg sclk_o,
  output reg sclk_oe_o,
  output reg sdo_o,
  output reg sdo_oe_o,
  input wire sdi_i
);
  reg [7:0] ctlb_r;
  reg [7:0] ctlc_r;
  reg [11:0] div_r;
  reg [11:0] pre_r;
  reg txc_r;
  reg [7:0] txbuf_r;
  reg txfull_r;
  reg [7:0] sh_r;
  reg busy_r;
  reg [3:0] bits_r;
  reg half_r;
  reg [7:0] rxq0_r;
  reg [7:0] rxq1_r;
  reg [1:0] rxcnt_r;
  reg [7:0] rxsh_r;
  reg rx_en_frame_r;
  // Every request is answered, even a write that sel_i[0] masks
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i & sel_i[0];
  wire rd = req & ~we_i;
  wire spi_mode = (ctlc_r[7:6] == `USM_MODE_SPI);
  wire pol = ctlc_r[`USM_BIT_POL];
  wire pha = ctlc_r[`USM_BIT_PHASE];
  wire lsb_first = ctlc_r[`USM_BIT_ORDER];
  wire txen = ctlb_r[`USM_BIT_TXEN];
  wire rxen = ctlb_r[`USM_BIT_RXEN];
  wire wr_data = wr & (adr_i == `USM_OFF_DATA);
  wire rd_data = rd & (adr_i == `USM_OFF_DATA) & sel_i[0];
  wire tick = busy_r & (pre_r == 12'h000);
  // Leading half-edge: sample in phase 0, setup in phase 1
  wire lead_edge = tick & ~half_r;
  wire trail_edge = tick & half_r;
  wire sample_ev = pha ? trail_edge : lead_edge;
  wire shift_ev = pha ? lead_edge : trail_edge;
  wire last_bit = (bits_r == `USM_FRAME_BITS - 4'h1);
  wire frame_done = trail_edge & last_bit;
  wire load_now = spi_mode & txen & txfull_r & (~busy_r | frame_done);
  wire [7:0] rx_bits = lsb_first ? {sdi_i, rxsh_r[7:1]} : {rxsh_r[6:0], sdi_i};
  // Phase 0 takes its last sample half a period before the frame ends
  wire [7:0] rx_byte = pha ? rx_bits : rxsh_r;

  function [0:0] out_bit;
    input [7:0] v;
    input lsb;
    begin
      out_bit = lsb ? v[0] : v[7];
    end
  endfunction

  function [7:0] shift_next;
    input [7:0] v;
    input lsb;
    begin
      shift_next = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
    end
  endfunction

  // Register bus: one-cycle answer, ack for one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= 32'h00000000;
      if (rd)
      begin
        case (adr_i)
          // Error flags stay zero in this mode
          `USM_OFF_STAT: dat_o[7:0] <= {(rxcnt_r != 2'h0), txc_r, ~txfull_r, 5'h00};
          `USM_OFF_CTLB: dat_o[7:0] <= ctlb_r;
          `USM_OFF_CTLC: dat_o[7:0] <= ctlc_r;
          `USM_OFF_DIVL: dat_o[7:0] <= div_r[7:0];
          `USM_OFF_DIVH: dat_o[7:0] <= {4'h0, div_r[11:8]};
          `USM_OFF_DATA: dat_o[7:0] <= rxq0_r;
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control registers; register locations are common to all modes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctlb_r <= 8'h00;
      ctlc_r <= `USM_CTLC_RESET;
      div_r <= 12'h000;
    end
    else if (wr)
    begin
      case (adr_i)
        `USM_OFF_CTLB: ctlb_r <= {3'h0, dat_i[4:3], 3'h0};
        `USM_OFF_CTLC: ctlc_r <= dat_i[7:0];
        `USM_OFF_DIVL: div_r[7:0] <= dat_i[7:0];
        `USM_OFF_DIVH: div_r[11:8] <= dat_i[3:0];
        default: ctlb_r <= ctlb_r;
      endcase
    end
  end

  // Prescaler: tick every div+1 clocks, two ticks per serial period
  always @(posedge clk_i)
  begin
    if (rst_i)
      pre_r <= 12'h000;
    else if (wr & (adr_i == `USM_OFF_DIVL))
      pre_r <= {div_r[11:8], dat_i[7:0]};
    else if (~busy_r | (pre_r == 12'h000))
      pre_r <= div_r;
    else
      pre_r <= pre_r - 12'h001;
  end

  // Common transfer controller; no parity or clock recovery exists here
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txbuf_r <= 8'h00;
      txfull_r <= 1'b0;
      sh_r <= 8'h00;
      busy_r <= 1'b0;
      bits_r <= 4'h0;
      half_r <= 1'b0;
      txc_r <= 1'b0;
      rx_en_frame_r <= 1'b0;
    end
    else
    begin
      if (load_now)
      begin
        sh_r <= txbuf_r;
        busy_r <= 1'b1;
        bits_r <= 4'h0;
        half_r <= 1'b0;
        rx_en_frame_r <= rxen;
      end
      else if (frame_done)
      begin
        busy_r <= 1'b0;
        bits_r <= 4'h0;
        half_r <= 1'b0;
      end
      else if (tick)
      begin
        half_r <= ~half_r;
        if (half_r)
          bits_r <= bits_r + 4'h1;
        if (shift_ev & ~(pha & ~half_r & (bits_r == 4'h0)))
          sh_r <= shift_next(sh_r, lsb_first);
      end
      // Buffer empties on load; a write refills it even in the same cycle
      if (wr_data)
      begin
        txbuf_r <= dat_i[7:0];
        txfull_r <= 1'b1;
      end
      else if (load_now)
        txfull_r <= 1'b0;
      // Complete only when both buffer and shifter are drained
      if (frame_done & ~txfull_r)
        txc_r <= 1'b1;
      else if (wr & (adr_i == `USM_OFF_STAT) & dat_i[`USM_BIT_TXC])
        txc_r <= 1'b0;
    end
  end

  // Receive path: two-level queue, newest byte dropped when full
  always @(posedge clk_i)
  begin
    if (rst_i | ~rxen)
    begin
      rxsh_r <= 8'h00;
      rxq0_r <= 8'h00;
      rxq1_r <= 8'h00;
      rxcnt_r <= 2'h0;
    end
    else
    begin
      if (sample_ev)
        rxsh_r <= rx_bits;
      if (frame_done & rx_en_frame_r & rd_data)
      begin
        case (rxcnt_r)
          2'h1: rxq0_r <= rx_byte;
          2'h2: rxq0_r <= rxq1_r;
          default: rxq0_r <= rx_byte;
        endcase
        if (rxcnt_r == 2'h2)
          rxq1_r <= rx_byte;
        if (rxcnt_r == 2'h0)
          rxcnt_r <= 2'h1;
      end
      else if (frame_done & rx_en_frame_r)
      begin
        if (rxcnt_r == 2'h0)
          rxq0_r <= rx_byte;
        else if (rxcnt_r == 2'h1)
          rxq1_r <= rx_byte;
        if (rxcnt_r != 2'h2)
          rxcnt_r <= rxcnt_r + 2'h1;
      end
      else if (rd_data & (rxcnt_r != 2'h0))
      begin
        rxq0_r <= rxq1_r;
        rxcnt_r <= rxcnt_r - 2'h1;
      end
    end
  end

  // Pins: first bit from the buffer on load in phase 0, the rest from the shifter
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_o <= 1'b0;
      sclk_oe_o <= 1'b0;
      sdo_o <= 1'b1;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      sclk_oe_o <= spi_mode & txen;
      sdo_oe_o <= spi_mode & txen;
      // Polarity 0: leading edge rises; polarity 1 inverts it
      if (busy_r & ~(load_now | frame_done))
        sclk_o <= pol ^ (half_r ^ tick);
      else
        sclk_o <= pol;
      // Phase 1 samples on the trailing edge, so sdo must not move there
      if (load_now)
      begin
        if (~pha)
          sdo_o <= out_bit(txbuf_r, lsb_first);
      end
      else if (shift_ev & ~frame_done)
      begin
        if (pha & ~half_r & (bits_r == 4'h0))
          sdo_o <= out_bit(sh_r, lsb_first);
        else
          sdo_o <= out_bit(shift_next(sh_r, lsb_first), lsb_first);
      end
      else if (~busy_r | (frame_done & ~pha))
        sdo_o <= 1'b1;
    end
  end
endmodule

// *** tb/usm_sva.sv ***
/* Checker on the ports of usm_top.
   Assumes the bind below and a synchronous active-high reset. */
`timescale 1ns/1ns
module usm_sva
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire sclk_oe_o,
  input wire sdo_o,
  input wire sdo_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd = cyc_i && stb_i && !we_i;
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack unasked");
  chk_rst_idle: assert property ($fell(rst_i) |-> !ack_o && sdo_o && !sclk_oe_o)
    else $error("reset state");
  chk_oe_pair: assert property (sdo_oe_o == sclk_oe_o)
    else $error("enables differ");
  chk_idle_high: assert property (!sdo_oe_o |-> sdo_o)
    else $error("data not idle");
  chk_err_zero: assert property (ack_o && $past(rd && adr_i == 8'hC0) |-> !dat_o[4:0])
    else $error("error flags set");
  chk_divh_bits: assert property (ack_o && $past(rd && adr_i == 8'hC5) |-> !dat_o[31:4])
    else $error("divisor high bits");
endmodule
bind usm_top usm_sva chk (.*);

// *** tb/usm_slave.sv ***
/* SPI slave model on the serial pins.
   Assumes pins synchronous to clk_i. */
`timescale 1ns/1ns
module usm_slave
(
  input wire clk_i,
  input wire sclk_i,
  input wire sdo_i,
  input wire oe_i,
  input wire smp_rise_i,
  input wire [15:0] tx_i,
  output wire sdi_o,
  output logic [15:0] rx_o
);
  logic sc_q = 1'b0;
  logic [3:0] cnt = 4'h0;
  // Sample edge is rising when polarity equals phase
  wire smp = oe_i && sclk_i != sc_q && sclk_i == smp_rise_i;
  always @(posedge clk_i)
  begin
    sc_q <= sclk_i;
    if (smp)
    begin
      rx_o <= {rx_o[14:0], sdo_i};
      cnt <= cnt + 4'h1;
    end
  end
  // Line is not held while oe_i is low, so show the inverted bit there
  assign sdi_o = tx_i[4'hF - cnt] ^ !oe_i;
endmodule

// *** tb/tb_top.sv ***
/* Self-checking bench for usm_top with an SPI slave model.
   Assumes checker and slave model compiled before it. */
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sc = 0;
  logic [3:0] sel_i = 4'hF;
  logic [7:0] adr_i = 0, d, st;
  logic [31:0] dat_i = 0;
  wire [31:0] dat_o;
  wire ack_o, sclk_o, sclk_oe_o, sdo_o, sdo_oe_o, sdi_i;
  logic [2:0] md = 0;
  logic [15:0] tx = 0, rx, w;
  logic [8:0] q[$];
  int error_cnt = 0, check_count = 0, hp = 0, hc = 0;
  usm_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .sdi_i(sdi_i));
  usm_slave sl (.clk_i(clk_i), .sclk_i(sclk_o), .sdo_i(sdo_o), .oe_i(sclk_oe_o),
    .smp_rise_i(md[0] == md[1]), .tx_i(tx), .sdi_o(sdi_i), .rx_o(rx));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [31:0] s, x);
    check_count++;
    if (s !== x)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic w1, input logic [7:0] a, dt, input logic [8:0] e);
    if (!w1)
      q.push_back(e);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w1;
    adr_i <= a;
    dat_i <= {24'h0, dt};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    st = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  function automatic logic [7:0] rv(input logic [7:0] v, input logic l);
    rv = v;
    if (l)
      for (int i = 0; i < 8; i++)
        rv[i] = v[7 - i];
  endfunction
  // Compare and pop in one process so the oldest note is the one compared
  always @(posedge clk_i)
    if (ack_o === 1'b1 && !we_i)
    begin
      if (!q[0][8])
        chk("read", dat_o, {24'h0, q[0][7:0]});
      void'(q.pop_front());
    end
  // Half period seen between sclk changes while driven
  always @(posedge clk_i)
  begin
    sc <= sclk_o;
    hc <= hc + 1;
    if (sclk_o != sc && sclk_oe_o)
    begin
      hp <= hc;
      hc <= 1;
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    close_out;
  end
  initial
  begin
    void'($urandom(32'h7a01dc91));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'hC4, 0, 9'h000);
    wb(0, 8'hC5, 0, 9'h000);
    wb(0, 8'hC2, 0, 9'h006);
    wb(0, 8'hC0, 0, 9'h020);
    wb(0, 8'hC3, 0, 9'h000);
    wb(1, 8'hC1, 8'h08, 0);
    chk("oe", {sclk_oe_o, sdo_oe_o}, 0);
    $display("reset test done");
    for (int m = 0; m < 8; m++)
    begin
      wb(1, 8'hC1, 0, 0);
      md = m[2:0];
      d = $urandom_range(3);
      tx = $urandom;
      w = $urandom;
      wb(1, 8'hC4, 0, 0);
      wb(1, 8'hC2, {5'h18, md}, 0);
      wb(1, 8'hC1, 8'h18, 0);
      wb(1, 8'hC5, 8'hF0, 0);
      wb(0, 8'hC5, 0, 9'h000);
      wb(1, 8'hC4, d, 0);
      wb(1, 8'hC0, 8'h40, 0);
      for (int i = 1; i >= 0; i--)
      begin
        st = 0;
        while (!st[5]) wb(0, 8'hC0, 0, 9'h100);
        wb(1, 8'hC6, w[8*i+:8], 0);
      end
      st = 0;
      while (!st[6]) wb(0, 8'hC0, 0, 9'h100);
      chk("half", hp, d + 1);
      chk("sclk", sclk_o, md[0]);
      chk("sdo", sdo_o, 1);
      chk("oe", {sclk_oe_o, sdo_oe_o}, 3);
      chk("mosi", rx, {rv(w[15:8], md[2]), rv(w[7:0], md[2])});
      wb(0, 8'hC6, 0, {1'b0, rv(tx[15:8], md[2])});
      wb(0, 8'hC6, 0, {1'b0, rv(tx[7:0], md[2])});
      $display("mode test %0d done", m);
    end
    // Three frames unread: the third is dropped, the first two kept
    wb(1, 8'hC0, 8'h40, 0);
    for (int i = 0; i < 3; i++)
    begin
      st = 0;
      while (!st[5]) wb(0, 8'hC0, 0, 9'h100);
      wb(1, 8'hC6, w[7:0], 0);
    end
    st = 0;
    while (!st[6]) wb(0, 8'hC0, 0, 9'h100);
    wb(0, 8'hC0, 0, 9'h0E0);
    wb(0, 8'hC6, 0, {1'b0, rv(tx[15:8], md[2])});
    wb(0, 8'hC6, 0, {1'b0, rv(tx[7:0], md[2])});
    wb(0, 8'hC0, 0, 9'h060);
    $display("overflow test done");
    // Transmitter alone, receiver off
    wb(1, 8'hC1, 8'h08, 0);
    wb(1, 8'hC0, 8'h40, 0);
    wb(1, 8'hC6, w[15:8], 0);
    st = 0;
    while (!st[6]) wb(0, 8'hC0, 0, 9'h100);
    chk("mosi", rx[7:0], rv(w[15:8], md[2]));
    wb(0, 8'hC0, 0, 9'h060);
    $display("transmit only test done");
    close_out;
  end
endmodule
